/* src/lsc_light_strobe.sv */
`timescale 1ns/1ps
`include "lsc_defs.svh"
module lsc_light_strobe (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // axi4-lite write
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // input lines and counter outputs
  input  wire logic [3:0]  lineIn,
  input  wire logic [3:0]  counterIn,
  // light side
  output logic [3:0]       pinOut,
  output logic [2:0]       overdrive
);
  // ************************************************************
  // register file
  // ************************************************************
  lsc_pkg::lsc_chan_t cfg [3];       // per-channel settings
  logic [1:0]  chSel;                // selected channel
  logic [3:0]  staticBits;           // user output bits
  logic [1:0]  pinSel;               // selected output pin
  logic [1:0]  pinOrigin [4];        // channel routed to each pin
  logic [5:0]  awAddr;               // held write address
  logic [31:0] wData;                // held write data
  logic        awHeld;               // address captured
  logic        wHeld;                // data captured
  logic [2:0]  srcBit;               // selected source per channel
  logic [2:0]  timerActive;          // timed pulse on per channel
  logic [2:0]  lampQ;                // modulated drive per channel
  logic [3:0]  lineMeta;             // first sync stage
  logic [3:0]  lineSync;             // second sync stage
  logic [6:0]  pwmCnt;               // internal modulation phase
  logic        doWrite;              // both halves present
  // map an address to a known register
  function automatic logic isMapped(input logic [5:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= `LSC_A_STATUS);
  endfunction
  // lines come from pins, two flops before use
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lineMeta <= 4'h0;
      lineSync <= 4'h0;
    end else begin
      lineMeta <= lineIn;
      lineSync <= lineMeta;
    end
  end
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  // write address and data captured in either order
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 6'h00;
      wData  <= 32'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LSC_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr) ? `LSC_RESP_OK : `LSC_RESP_ERR;
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // response taken, open for the next write
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // register writes, settings land in the selected channel
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chSel      <= 2'h0;
      staticBits <= 4'h0;
      pinSel     <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        cfg[i] <= '0;
      end
      for (int p = 0; p < 4; p++) begin
        pinOrigin[p] <= (p == 3) ? 2'h0 : `LSC_PIN_OFF;
      end
    end else if (doWrite) begin
      case (awAddr)
        `LSC_A_CHSEL:  if (wData[1:0] != 2'h3) chSel <= wData[1:0];
        `LSC_A_ORIGIN: cfg[chSel].origin    <= wData[3:0];
        `LSC_A_AMP:    cfg[chSel].ampLimit  <= wData;
        `LSC_A_VOLT:   cfg[chSel].voltLimit <= wData;
        `LSC_A_PCT:    cfg[chSel].pct       <= wData[15:0];
        `LSC_A_LEAD:   cfg[chSel].lead      <= wData;
        `LSC_A_WIDTH:  cfg[chSel].width     <= wData;
        `LSC_A_HOLD:   cfg[chSel].holdoff   <= wData;
        `LSC_A_TRIG:   cfg[chSel].trig      <= wData[3:0];
        `LSC_A_STATIC: staticBits <= wData[3:0];
        `LSC_A_PINSEL: pinSel     <= wData[1:0];
        // hard-wired pin keeps its fixed routing
        `LSC_A_PINORG: if (pinSel != 2'h3) pinOrigin[pinSel] <= wData[1:0];
        default: ;
      endcase
    end
  end
  // read channel, answer one cycle after address taken
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `LSC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= isMapped(s_axi_araddr) ? `LSC_RESP_OK : `LSC_RESP_ERR;
      case (s_axi_araddr)
        `LSC_A_CHSEL:  s_axi_rdata <= {30'h0, chSel};
        `LSC_A_ORIGIN: s_axi_rdata <= {28'h0, cfg[chSel].origin};
        `LSC_A_AMP:    s_axi_rdata <= cfg[chSel].ampLimit;
        `LSC_A_VOLT:   s_axi_rdata <= cfg[chSel].voltLimit;
        `LSC_A_PCT:    s_axi_rdata <= {16'h0, cfg[chSel].pct};
        `LSC_A_LEAD:   s_axi_rdata <= cfg[chSel].lead;
        `LSC_A_WIDTH:  s_axi_rdata <= cfg[chSel].width;
        `LSC_A_HOLD:   s_axi_rdata <= cfg[chSel].holdoff;
        `LSC_A_TRIG:   s_axi_rdata <= {28'h0, cfg[chSel].trig};
        `LSC_A_STATIC: s_axi_rdata <= {28'h0, staticBits};
        `LSC_A_PINSEL: s_axi_rdata <= {30'h0, pinSel};
        `LSC_A_PINORG: s_axi_rdata <= {30'h0, pinOrigin[pinSel]};
        `LSC_A_STATUS: s_axi_rdata <= {24'h0, 1'b0, timerActive, 1'b0, lampQ};
        default:       s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ************************************************************
  // internal modulation, hidden from software
  // ************************************************************
  // free-running phase 0..99
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwmCnt <= 7'h00;
    end else begin
      pwmCnt <= (pwmCnt == 7'h63) ? 7'h00 : pwmCnt + 7'h01;
    end
  end

  // ************************************************************
  // channels
  // ************************************************************
  for (genvar c = 0; c < 3; c++) begin : gChan
    lsc_pkg::lsc_state_t state;        // timed pulse state
    logic [31:0]         cnt;          // phase counter
    logic                trigPrev;     // last trigger level
    logic                trigLvl;      // selected trigger line
    logic                fire;         // trigger condition met
    logic [1:0]          kind;         // source kind
    logic [1:0]          idx;          // source index
    logic [15:0]         effPct;       // brightness actually applied

    assign kind    = cfg[c].origin[1:0];
    assign idx     = cfg[c].origin[3:2];
    assign trigLvl = lineSync[cfg[c].trig[1:0]];
    // source selection
    always_comb begin
      case (kind)
        `LSC_SRC_LINE:  srcBit[c] = lineSync[idx];
        `LSC_SRC_TIMER: srcBit[c] = timerActive[(idx == 2'h3) ? 2'h0 : idx];
        `LSC_SRC_CNT:   srcBit[c] = counterIn[idx];
        default:        srcBit[c] = staticBits[idx];
      endcase
    end
    // trigger edge decode
    always_comb begin
      case (cfg[c].trig[3:2])
        `LSC_EDGE_RISE: fire = trigLvl && !trigPrev;
        `LSC_EDGE_FALL: fire = !trigLvl && trigPrev;
        `LSC_EDGE_ANY:  fire = trigLvl != trigPrev;
        default:        fire = trigLvl;
      endcase
    end
    // overdrive kept only for timer-sourced drive
    assign effPct = (kind == `LSC_SRC_TIMER || cfg[c].pct <= `LSC_PCT_FULL) ?
                    cfg[c].pct : `LSC_PCT_FULL;

    // timed pulse sequencer
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        state    <= lsc_pkg::LSC_IDLE;
        cnt      <= 32'h1;
        trigPrev <= 1'b0;
      end else begin
        trigPrev <= trigLvl;
        case (state)
          lsc_pkg::LSC_IDLE: begin
            cnt <= 32'h1;
            if (fire) begin
              state <= (cfg[c].lead == 32'h0) ? lsc_pkg::LSC_PULSE : lsc_pkg::LSC_LEAD;
            end
          end
          lsc_pkg::LSC_LEAD: begin
            if (cnt >= cfg[c].lead) begin
              state <= lsc_pkg::LSC_PULSE;
              cnt   <= 32'h1;
            end else begin
              cnt <= cnt + 32'h1;
            end
          end
          lsc_pkg::LSC_PULSE: begin
            if (cnt >= cfg[c].width) begin
              state <= lsc_pkg::LSC_HOLD;
              cnt   <= 32'h1;
            end else begin
              cnt <= cnt + 32'h1;
            end
          end
          lsc_pkg::LSC_HOLD: begin
            // triggers ignored until hold-off ends
            if (cnt >= cfg[c].holdoff) begin
              state <= lsc_pkg::LSC_IDLE;
            end else begin
              cnt <= cnt + 32'h1;
            end
          end
          default: state <= lsc_pkg::LSC_IDLE;
        endcase
      end
    end

    assign timerActive[c] = (state == lsc_pkg::LSC_PULSE);

    // drive level: off when source idle, else modulated
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        lampQ[c]     <= 1'b0;
        overdrive[c] <= 1'b0;
      end else begin
        lampQ[c] <= srcBit[c] && (effPct >= `LSC_PCT_FULL || {9'h0, pwmCnt} < effPct);
        overdrive[c] <= srcBit[c] && (effPct > `LSC_PCT_FULL);
      end
    end

    sequence sIdleFire;
      state == lsc_pkg::LSC_IDLE && fire;
    endsequence
    AST_LEAD_START: assert property (@(posedge clk_sys) disable iff (!arst_n)
      sIdleFire and (cfg[c].lead != 32'h0) |=> state == lsc_pkg::LSC_LEAD)
      else $error("lead phase not entered");
    AST_WIDTH_EXACT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $fell(timerActive[c]) |-> $past(cnt) == cfg[c].width || cfg[c].width == 32'h0)
      else $error("pulse width wrong");
    AST_HOLD_IGNORE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      state == lsc_pkg::LSC_HOLD && cnt < cfg[c].holdoff |=> state == lsc_pkg::LSC_HOLD)
      else $error("hold-off cut short");
    AST_OFF_IDLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !srcBit[c] |=> !lampQ[c] && !overdrive[c])
      else $error("light on with idle source");
    AST_NO_DC_OVER: assert property (@(posedge clk_sys) disable iff (!arst_n)
      overdrive[c] |-> $past(kind) == `LSC_SRC_TIMER && $past(timerActive[(idx == 2'h3) ? 2'h0 : idx]))
      else $error("overdrive outside timed pulse");
    AST_ZERO_DARK: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cfg[c].pct == 16'h0 && $stable(cfg[c].pct) |=> !lampQ[c])
      else $error("zero brightness lit");
    AST_FOLLOW_EXT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      kind != `LSC_SRC_TIMER && cfg[c].pct >= `LSC_PCT_FULL ##1 $stable(cfg[c].origin)
      |-> lampQ[c] == $past(srcBit[c]))
      else $error("full brightness not followed");
  end

  // ************************************************************
  // output pin routing
  // ************************************************************
  // each pin takes the modulated drive of its routed channel
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pinOut <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        pinOut[p] <= (pinOrigin[p] == `LSC_PIN_OFF) ? 1'b0 : lampQ[pinOrigin[p]];
      end
    end
  end

  AST_PIN_FIXED: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ##1 pinOut[3] == $past(lampQ[0]))
    else $error("hard-wired pin not fed by channel 0");
  AST_CHSEL: assert property (@(posedge clk_sys) disable iff (!arst_n)
    doWrite && awAddr == `LSC_A_CHSEL && wData[1:0] != 2'h3 |=> chSel == $past(wData[1:0]))
    else $error("channel select not taken");
endmodule // lsc_light_strobe

/* src/lsc_defs.svh */
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH
// register byte offsets
`define LSC_A_CHSEL    6'h00
`define LSC_A_ORIGIN   6'h04
`define LSC_A_AMP      6'h08
`define LSC_A_VOLT     6'h0c
`define LSC_A_PCT      6'h10
`define LSC_A_LEAD     6'h14
`define LSC_A_WIDTH    6'h18
`define LSC_A_HOLD     6'h1c
`define LSC_A_TRIG     6'h20
`define LSC_A_STATIC   6'h24
`define LSC_A_PINSEL   6'h28
`define LSC_A_PINORG   6'h2c
`define LSC_A_STATUS   6'h30
// drive origin kinds
`define LSC_SRC_LINE   2'h0
`define LSC_SRC_TIMER  2'h1
`define LSC_SRC_CNT    2'h2
`define LSC_SRC_USER   2'h3
// trigger edge kinds
`define LSC_EDGE_RISE  2'h0
`define LSC_EDGE_FALL  2'h1
`define LSC_EDGE_ANY   2'h2
`define LSC_EDGE_HIGH  2'h3
// full brightness, pin-off code and response codes
`define LSC_PCT_FULL   16'h0064
`define LSC_PIN_OFF    2'h3
`define LSC_RESP_OK    2'h0
`define LSC_RESP_ERR   2'h2
`endif

/* src/lsc_pkg.sv */
package lsc_pkg;
  // one-hot timed pulse states
  typedef enum logic [3:0] {
    LSC_IDLE  = 4'h1,
    LSC_LEAD  = 4'h2,
    LSC_PULSE = 4'h4,
    LSC_HOLD  = 4'h8
  } lsc_state_t;
  // per-channel settings
  typedef struct packed {
    logic [3:0]  origin;     // [1:0] kind, [3:2] index
    logic [31:0] ampLimit;   // current rating, milliamperes
    logic [31:0] voltLimit;  // voltage rating, millivolts
    logic [15:0] pct;        // brightness percent
    logic [31:0] lead;       // delay before pulse, cycles
    logic [31:0] width;      // pulse width, cycles
    logic [31:0] holdoff;    // re-arm hold-off, cycles
    logic [3:0]  trig;       // [1:0] line index, [3:2] edge kind
  } lsc_chan_t;
endpackage

/* verif/lsc_light_model.sv */
`timescale 1ns/1ps
// ****************************************
// light seen from one output pin
// ****************************************
module lsc_light_model (
  // clock and bench control
  input  wire logic clk_sys,
  input  wire logic clr,
  // light drive
  input  wire logic pin,
  input  wire logic od,
  // observed figures
  output int        pulses,
  output int        lastWidth,
  output int        lastGap,
  output logic      odSeen
);
  int run;  // cycles lit in the current pulse
  int gap;  // cycles dark since the last pulse

  initial begin
    pulses    = 0;
    lastWidth = 0;
    lastGap   = 0;
    odSeen    = 1'b0;
    run       = 0;
    gap       = 0;
  end

  // the light only integrates drive; it counts pulses and their widths
  always @(posedge clk_sys) begin
    if (clr) begin
      pulses = 0;
      odSeen = 1'b0;
    end
    if (pin) begin
      // spacing between lit periods, for overdrive safety
      if (run == 0) lastGap = gap;
      run++;
      gap = 0;
      if (od) odSeen = 1'b1;
    end else begin
      // a finished pulse is counted on its falling edge
      if (run > 0) begin
        pulses++;
        lastWidth = run;
      end
      run = 0;
      gap++;
    end
  end
endmodule // lsc_light_model

/* verif/lsc_light_strobe_tb.sv */
`timescale 1ns/1ps
`include "lsc_defs.svh"
module lsc_light_strobe_tb;
  logic        clk_sys;    // bench clock
  logic        arst_n;     // reset, active low
  logic [5:0]  awAddr;     // write channels
  logic        awValid;
  logic        awReady;
  logic [31:0] wData;
  logic        wValid;
  logic        wReady;
  logic [1:0]  bResp;
  logic        bValid;
  logic        bReady;
  logic [5:0]  arAddr;     // read channels
  logic        arValid;
  logic        arReady;
  logic [31:0] rData;
  logic [1:0]  rResp;
  logic        rValid;
  logic        rReady;
  logic [3:0]  lineIn;     // light sources
  logic [3:0]  counterIn;
  logic [3:0]  pinOut;     // light side
  logic [2:0]  overdrive;
  logic        clr;        // clears the model's pulse count and overdrive flag
  int          pulses;
  int          lastWidth;
  int          lastGap;
  logic        odSeen;
  int          n_errors;
  int          n_checks;
  int          cyc;        // timeout counter
  logic [31:0] rd;         // last read data
  logic [1:0]  rsp;        // last response
  logic [31:0] ex;         // expected pin level

  lsc_light_strobe lsc_light_strobe_inst (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .lineIn(lineIn), .counterIn(counterIn), .pinOut(pinOut), .overdrive(overdrive));

  lsc_light_model lsc_light_model_inst (
    .clk_sys(clk_sys), .clr(clr), .pin(pinOut[0]), .od(overdrive[0]),
    .pulses(pulses), .lastWidth(lastWidth), .lastGap(lastGap), .odSeen(odSeen));

  // ****************************************
  // bench tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awAddr  <= a;
    wData   <= d;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!(bValid && bReady));
    rsp = bResp;
    bReady <= 1'b0;
  endtask

  // read one word and compare data and response
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_sys);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arValid && arReady) arValid <= 1'b0;
    end while (!(rValid && rReady));
    rd = rData;
    rsp = rResp;
    rReady <= 1'b0;
    chk(rd, exp);
    chk(32'(rsp), 32'(er));
  endtask

  // one pulse on an input line, n cycles long
  task automatic pulse_line(input int b, input int n);
    lineIn[b] <= 1'b1;
    cycles(n);
    lineIn[b] <= 1'b0;
  endtask

  task automatic clear();
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
  endtask

  // ****************************************
  // clock, timeout and sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    {arst_n, awAddr, awValid, wData, wValid, bReady} = '0;
    {arAddr, arValid, rReady, lineIn, counterIn, clr} = '0;
    cycles(20);
    arst_n <= 1'b1;
    // reset values and refused accesses
    rchk(`LSC_A_CHSEL, 32'h0, `LSC_RESP_OK);
    rchk(`LSC_A_PINORG, 32'(`LSC_PIN_OFF), `LSC_RESP_OK);
    rchk(6'h34, 32'h0, `LSC_RESP_ERR);
    wr(6'h38, 32'h1);
    chk(32'(rsp), 32'(`LSC_RESP_ERR));
    wr(`LSC_A_PINSEL, 32'h3);
    wr(`LSC_A_PINORG, 32'h2);
    rchk(`LSC_A_PINORG, 32'h0, `LSC_RESP_OK);
    // settings held per channel
    wr(`LSC_A_CHSEL, 32'h1);
    wr(`LSC_A_AMP, 32'h000005dc);
    wr(`LSC_A_VOLT, 32'h00005dc0);
    wr(`LSC_A_PCT, 32'h00000096);
    wr(`LSC_A_CHSEL, 32'h3);
    rchk(`LSC_A_CHSEL, 32'h1, `LSC_RESP_OK);
    rchk(`LSC_A_AMP, 32'h000005dc, `LSC_RESP_OK);
    rchk(`LSC_A_VOLT, 32'h00005dc0, `LSC_RESP_OK);
    rchk(`LSC_A_PCT, 32'h00000096, `LSC_RESP_OK);
    wr(`LSC_A_CHSEL, 32'h0);
    rchk(`LSC_A_AMP, 32'h0, `LSC_RESP_OK);
    wr(`LSC_A_PINSEL, 32'h0);
    wr(`LSC_A_PINORG, 32'h0);
    rchk(`LSC_A_PINORG, 32'h0, `LSC_RESP_OK);
    wr(`LSC_A_PINSEL, 32'h1);
    wr(`LSC_A_PINORG, 32'h0);
    wr(`LSC_A_PCT, 32'(`LSC_PCT_FULL));
    // line opposite to counter and user bit, so the chosen source shows
    for (int v = 1; v >= 0; v--) begin
      lineIn    <= 4'(v);
      counterIn <= 4'(1 - v);
      wr(`LSC_A_STATIC, 32'(1 - v));
      for (int k = 0; k < 4; k++) begin
        if (k != 1) begin
          wr(`LSC_A_ORIGIN, 32'(k));
          cycles(8);
          ex = (k == 0) ? 32'(v) : 32'(1 - v);
          chk(32'(pinOut[0]), ex);
          chk(32'(pinOut[1]), ex);
          chk(32'(pinOut[3]), ex);
          chk(32'(pinOut[2]), 32'h0);
        end
      end
    end
    // overdrive asked for on a static source is clamped
    wr(`LSC_A_STATIC, 32'h1);
    wr(`LSC_A_PCT, 32'h000000fa);
    cycles(8);
    chk(32'(pinOut[0]), 32'h1);
    chk(32'(overdrive[0]), 32'h0);
    // half brightness lights half of each modulation period
    wr(`LSC_A_PCT, 32'd50);
    clear();
    cycles(250);
    chk(32'(lastWidth), 32'd50);
    chk(32'(pulses >= 2), 32'h1);
    // external pulse keeps its length
    wr(`LSC_A_ORIGIN, 32'h4);
    wr(`LSC_A_PCT, 32'(`LSC_PCT_FULL));
    clear();
    pulse_line(1, 10);
    cycles(8);
    chk(32'(pulses), 32'h1);
    chk(32'(lastWidth), 32'd10);
    // timed pulse, overdriven, with hold-off
    wr(`LSC_A_LEAD, 32'h3);
    wr(`LSC_A_WIDTH, 32'h5);
    wr(`LSC_A_HOLD, 32'd40);
    wr(`LSC_A_TRIG, 32'h2);
    wr(`LSC_A_PCT, 32'h000000fa);
    wr(`LSC_A_ORIGIN, 32'(`LSC_SRC_TIMER));
    clear();
    pulse_line(2, 3);
    cycles(20);
    chk(32'(pulses), 32'h1);
    chk(32'(lastWidth), 32'h5);
    chk(32'(odSeen), 32'h1);
    pulse_line(2, 3);
    cycles(20);
    chk(32'(pulses), 32'h1);
    cycles(40);
    pulse_line(2, 3);
    cycles(20);
    chk(32'(pulses), 32'h2);
    chk(32'(lastGap > 40), 32'h1);
    // falling edge trigger kind
    wr(`LSC_A_TRIG, 32'h6);
    clear();
    // let the hold-off of the last pulse run out first
    cycles(60);
    lineIn[2] <= 1'b1;
    cycles(60);
    chk(32'(pulses), 32'h0);
    lineIn[2] <= 1'b0;
    cycles(20);
    chk(32'(pulses), 32'h1);
    // any-edge trigger kind fires on both edges
    wr(`LSC_A_TRIG, 32'h0a);
    clear();
    cycles(60);
    lineIn[2] <= 1'b1;
    cycles(20);
    chk(32'(pulses), 32'h1);
    cycles(60);
    lineIn[2] <= 1'b0;
    cycles(20);
    chk(32'(pulses), 32'h2);
    summarize();
  end
endmodule // lsc_light_strobe_tb
